// File: mbs_operand_resolve.sv
package mbs_pkg;
    // instruction patterns (value and care mask)
    localparam logic [15:0] MBS_MOVE_FP_VAL = 16'h6000;
    localparam logic [15:0] MBS_MOVE_FP_MSK = 16'he000;
    localparam logic [15:0] MBS_BANK_LO_VAL = 16'hb800;
    localparam logic [15:0] MBS_BANK_LO_MSK = 16'hff00;
    localparam logic [15:0] MBS_BANK_HI_VAL = 16'hba00;
    localparam logic [15:0] MBS_BANK_HI_MSK = 16'hfe00;
    localparam logic [15:0] MBS_LIT_W_VAL = 16'hb000;
    localparam logic [15:0] MBS_LIT_W_MSK = 16'hff00;
    localparam logic [15:0] MBS_LONG_CALL_VAL = 16'hb700;
    localparam logic [15:0] MBS_LONG_CALL_MSK = 16'hff00;
    // operand field positions
    localparam int MBS_FILE_LSB = 0;
    localparam int MBS_PERIPH_LSB = 8;
    localparam int MBS_BANK_LO_LSB = 0;
    localparam int MBS_BANK_HI_LSB = 4;
    // special data-space locations
    localparam logic [7:0] MBS_INDIRECT0_ADDR = 8'h00;
    localparam logic [7:0] MBS_INDIRECT1_ADDR = 8'h08;
    localparam logic [7:0] MBS_WORKING_ADDR = 8'h0a;
    // reset values and the long-call return-address step
    localparam logic [7:0] MBS_WORKING_RST = 8'h00;
    localparam logic [7:0] MBS_BANK_RST = 8'h00;
    localparam logic [15:0] MBS_PC_STEP = 16'h0001;

    typedef enum logic [1:0] {
        MBS_Q_DECODE = 2'b00,
        MBS_Q_READ = 2'b01,
        MBS_Q_PROCESS = 2'b10,
        MBS_Q_WRITE = 2'b11
    } mbs_phase_t;

    typedef enum logic [2:0] {
        MBS_OP_NONE = 3'b000,
        MBS_OP_MOVE_FP = 3'b001,
        MBS_OP_BANK_LO = 3'b010,
        MBS_OP_BANK_HI = 3'b011,
        MBS_OP_LIT_W = 3'b100,
        MBS_OP_LONG_CALL = 3'b101
    } mbs_op_t;

    // masked compare leaves don't-care bits out of the decision
    function automatic logic mbs_match(input logic [15:0] word, input logic [15:0] val, input logic [15:0] msk);
        return (word & msk) == val;
    endfunction

    function automatic mbs_op_t mbs_decode(input logic [15:0] word);
        mbs_op_t op;
        op = MBS_OP_NONE;
        if (mbs_match(word, MBS_MOVE_FP_VAL, MBS_MOVE_FP_MSK)) begin
            op = MBS_OP_MOVE_FP;
        end else if (mbs_match(word, MBS_BANK_LO_VAL, MBS_BANK_LO_MSK)) begin
            op = MBS_OP_BANK_LO;
        end else if (mbs_match(word, MBS_BANK_HI_VAL, MBS_BANK_HI_MSK)) begin
            op = MBS_OP_BANK_HI;
        end else if (mbs_match(word, MBS_LIT_W_VAL, MBS_LIT_W_MSK)) begin
            op = MBS_OP_LIT_W;
        end else if (mbs_match(word, MBS_LONG_CALL_VAL, MBS_LONG_CALL_MSK)) begin
            op = MBS_OP_LONG_CALL;
        end
        return op;
    endfunction
endpackage

`timescale 1ns/1ps
// maps an operand address through the indirect registers and flags the working register
module mbs_operand_resolve
    import mbs_pkg::*;
(
    // operand in
    input wire logic [7:0] addr_i,
    // indirect pointers
    input wire logic [7:0] ptr0_i,
    input wire logic [7:0] ptr1_i,
    // resolved operand
    output logic [7:0] addr_o,
    output logic is_working_o
);
    logic [7:0] eff;

    // one level of indirection only; a pointer aimed at an indirect slot is not followed again
    always_comb begin
        eff = addr_i;
        if (addr_i == MBS_INDIRECT0_ADDR) begin
            eff = ptr0_i;
        end else if (addr_i == MBS_INDIRECT1_ADDR) begin
            eff = ptr1_i;
        end
        addr_o = eff;
        is_working_o = (eff == MBS_WORKING_ADDR);
    end
endmodule

// File: mbs_move_bank_decode.sv
`timescale 1ns/1ps
// Contract
// - move opcode copies file f into p
// - source spans 256 locations, destination lowest 32
// - either operand may be working register
// - both operands resolve through indirect registers
// - low bank load sets bits 3:0 only
// - high bank load sets bits 7:4 only
// - literal load into working register, one cycle
// - long call pushes return, loads pc
module mbs_move_bank_decode
    import mbs_pkg::*;
(
    // clock and reset
    input wire logic REF_CLK_I,
    input wire logic RST_B_I,
    // instruction fetch
    input wire logic [15:0] INSTR_I,
    input wire logic INSTR_VALID_I,
    output logic INSTR_READY_O,
    // program counter context
    input wire logic [15:0] PC_I,
    input wire logic [7:0] PC_HIGH_HOLDING_LATCH_I,
    // indirect pointers
    input wire logic [7:0] PTR0_I,
    input wire logic [7:0] PTR1_I,
    // data memory
    output logic [7:0] DMEM_ADDR_O,
    output logic DMEM_RD_O,
    input wire logic [7:0] DMEM_RDATA_I,
    output logic DMEM_WE_O,
    output logic [7:0] DMEM_WDATA_O,
    // stack and program counter load
    output logic STACK_PUSH_O,
    output logic [15:0] TOP_OF_STACK_O,
    output logic PC_LOAD_O,
    output logic [7:0] PC_LOW_BYTE_O,
    output logic [7:0] PC_HIGH_BYTE_O,
    // architectural registers
    output logic [7:0] WORKING_REGISTER_O,
    output logic [7:0] BANK_SELECT_REGISTER_O
);
    typedef struct packed {
        mbs_phase_t phase;
        mbs_op_t op;
        logic second;
        logic [15:0] instr;
        logic [7:0] data;
        logic [7:0] working;
        logic [7:0] bank;
        logic [7:0] dmem_addr;
        logic dmem_rd;
        logic dmem_we;
        logic [7:0] dmem_wdata;
        logic push;
        logic [15:0] top_of_stack;
        logic pc_load;
        logic [7:0] pc_lo;
        logic [7:0] pc_hi;
    } mbs_state_t;

    mbs_state_t st_r;
    mbs_state_t st_nxt;
    logic [1:0] rst_sync_r;
    logic rst_n;
    logic [7:0] src_addr;
    logic src_is_w;
    logic [7:0] dst_addr;
    logic dst_is_w;
    logic accept;

    // two-flop reset release; kept apart from the state struct so each variable has one process
    always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            rst_sync_r <= 2'b00;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    // source: full 8-bit file field from the word being fetched
    mbs_operand_resolve u_src (
        .addr_i(INSTR_I[MBS_FILE_LSB +: 8]),
        .ptr0_i(PTR0_I),
        .ptr1_i(PTR1_I),
        .addr_o(src_addr),
        .is_working_o(src_is_w)
    );

    // destination: 5-bit field, so direct addressing reaches only the lowest 32 locations
    mbs_operand_resolve u_dst (
        .addr_i({3'h0, st_r.instr[MBS_PERIPH_LSB +: 5]}),
        .ptr0_i(PTR0_I),
        .ptr1_i(PTR1_I),
        .addr_o(dst_addr),
        .is_working_o(dst_is_w)
    );

    // new words only at the decode phase of a free cycle
    assign INSTR_READY_O = rst_n && (st_r.phase == MBS_Q_DECODE) && !st_r.second;
    assign accept = INSTR_READY_O && INSTR_VALID_I;

    // move whose source resolved to the working register: decode strobed no read
    function automatic logic src_pending_w(input mbs_state_t s);
        return s.op == MBS_OP_MOVE_FP && !s.dmem_rd;
    endfunction

    // four-phase sequencer: decode, read, process, write
    always_comb begin
        st_nxt = st_r;
        st_nxt.dmem_rd = 1'b0; // strobes last one clock
        st_nxt.dmem_we = 1'b0;
        st_nxt.push = 1'b0;
        st_nxt.pc_load = 1'b0;
        unique case (st_r.phase)
            MBS_Q_DECODE: begin
                if (st_r.second) begin
                    st_nxt.phase = MBS_Q_READ; // idle second cycle of the long call
                end else if (accept) begin
                    st_nxt.instr = INSTR_I;
                    st_nxt.op = mbs_decode(INSTR_I);
                    st_nxt.phase = MBS_Q_READ;
                    if (mbs_decode(INSTR_I) == MBS_OP_MOVE_FP && !src_is_w) begin
                        st_nxt.dmem_addr = src_addr;
                        st_nxt.dmem_rd = 1'b1;
                    end
                end
            end
            MBS_Q_READ: begin
                st_nxt.phase = MBS_Q_PROCESS;
                // memory read is combinational, so data is sampled here
                st_nxt.data = (st_r.op == MBS_OP_MOVE_FP && !src_pending_w(st_r)) ? DMEM_RDATA_I
                    : st_r.working;
                if (st_r.op == MBS_OP_LIT_W || st_r.op == MBS_OP_LONG_CALL) begin
                    st_nxt.data = st_r.instr[7:0];
                end
            end
            MBS_Q_PROCESS: begin
                st_nxt.phase = MBS_Q_WRITE;
                if (!st_r.second && st_r.op == MBS_OP_MOVE_FP && !dst_is_w) begin
                    st_nxt.dmem_addr = dst_addr;
                    st_nxt.dmem_wdata = st_r.data;
                    st_nxt.dmem_we = 1'b1;
                end
                if (!st_r.second && st_r.op == MBS_OP_LONG_CALL) begin
                    st_nxt.top_of_stack = PC_I + MBS_PC_STEP;
                    st_nxt.push = 1'b1;
                    st_nxt.pc_lo = st_r.data;
                    st_nxt.pc_hi = PC_HIGH_HOLDING_LATCH_I;
                    st_nxt.pc_load = 1'b1;
                end
            end
            MBS_Q_WRITE: begin
                st_nxt.phase = MBS_Q_DECODE;
                if (st_r.second) begin
                    st_nxt.second = 1'b0;
                    st_nxt.op = MBS_OP_NONE;
                end else begin
                    // no status flags are touched by any of these
                    unique case (st_r.op)
                        MBS_OP_MOVE_FP: begin
                            if (dst_is_w) begin
                                st_nxt.working = st_r.data;
                            end
                        end
                        MBS_OP_BANK_LO: st_nxt.bank[3:0] = st_r.instr[MBS_BANK_LO_LSB +: 4];
                        MBS_OP_BANK_HI: st_nxt.bank[7:4] = st_r.instr[MBS_BANK_HI_LSB +: 4];
                        MBS_OP_LIT_W: st_nxt.working = st_r.data;
                        MBS_OP_LONG_CALL: st_nxt.second = 1'b1;
                        MBS_OP_NONE: st_nxt.op = MBS_OP_NONE;
                        default: st_nxt.op = MBS_OP_NONE;
                    endcase
                end
            end
        endcase
    end

    // everything except the reset synchroniser
    always_ff @(posedge REF_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            st_r.phase <= MBS_Q_DECODE;
            st_r.op <= MBS_OP_NONE;
            st_r.second <= 1'b0;
            st_r.instr <= 16'h0000;
            st_r.data <= 8'h00;
            st_r.working <= MBS_WORKING_RST;
            st_r.bank <= MBS_BANK_RST;
            st_r.dmem_addr <= 8'h00;
            st_r.dmem_rd <= 1'b0;
            st_r.dmem_we <= 1'b0;
            st_r.dmem_wdata <= 8'h00;
            st_r.push <= 1'b0;
            st_r.top_of_stack <= 16'h0000;
            st_r.pc_load <= 1'b0;
            st_r.pc_lo <= 8'h00;
            st_r.pc_hi <= 8'h00;
        end else begin
            st_r.phase <= st_nxt.phase;
            st_r.op <= st_nxt.op;
            st_r.second <= st_nxt.second;
            st_r.instr <= st_nxt.instr;
            st_r.data <= st_nxt.data;
            st_r.working <= st_nxt.working;
            st_r.bank <= st_nxt.bank;
            st_r.dmem_addr <= st_nxt.dmem_addr;
            st_r.dmem_rd <= st_nxt.dmem_rd;
            st_r.dmem_we <= st_nxt.dmem_we;
            st_r.dmem_wdata <= st_nxt.dmem_wdata;
            st_r.push <= st_nxt.push;
            st_r.top_of_stack <= st_nxt.top_of_stack;
            st_r.pc_load <= st_nxt.pc_load;
            st_r.pc_lo <= st_nxt.pc_lo;
            st_r.pc_hi <= st_nxt.pc_hi;
        end
    end

    // outputs straight from flops
    assign DMEM_ADDR_O = st_r.dmem_addr;
    assign DMEM_RD_O = st_r.dmem_rd;
    assign DMEM_WE_O = st_r.dmem_we;
    assign DMEM_WDATA_O = st_r.dmem_wdata;
    assign STACK_PUSH_O = st_r.push;
    assign TOP_OF_STACK_O = st_r.top_of_stack;
    assign PC_LOAD_O = st_r.pc_load;
    assign PC_LOW_BYTE_O = st_r.pc_lo;
    assign PC_HIGH_BYTE_O = st_r.pc_hi;
    assign WORKING_REGISTER_O = st_r.working;
    assign BANK_SELECT_REGISTER_O = st_r.bank;
endmodule

// File: mbs_move_bank_decode_sva.sv
`timescale 1ns/1ps
// watches decode, memory traffic and register updates at the top ports
module mbs_move_bank_decode_sva
    import mbs_pkg::*;
(
    input wire logic REF_CLK_I,
    input wire logic RST_B_I,
    input wire logic [15:0] INSTR_I,
    input wire logic INSTR_VALID_I,
    input wire logic INSTR_READY_O,
    input wire logic [15:0] PC_I,
    input wire logic [7:0] PC_HIGH_HOLDING_LATCH_I,
    input wire logic [7:0] PTR0_I,
    input wire logic [7:0] DMEM_ADDR_O,
    input wire logic DMEM_RD_O,
    input wire logic [7:0] DMEM_RDATA_I,
    input wire logic DMEM_WE_O,
    input wire logic [7:0] DMEM_WDATA_O,
    input wire logic STACK_PUSH_O,
    input wire logic [15:0] TOP_OF_STACK_O,
    input wire logic PC_LOAD_O,
    input wire logic [7:0] PC_LOW_BYTE_O,
    input wire logic [7:0] PC_HIGH_BYTE_O,
    input wire logic [7:0] WORKING_REGISTER_O,
    input wire logic [7:0] BANK_SELECT_REGISTER_O
);
    default clocking @(posedge REF_CLK_I); endclocking
    default disable iff (!RST_B_I);
    logic take, mv, pf, pp, lo, hi, lw, lc;
    // plain operands avoid the indirect and working slots
    function automatic logic plain(input logic [7:0] a);
        return a != MBS_INDIRECT0_ADDR && a != MBS_INDIRECT1_ADDR && a != MBS_WORKING_ADDR;
    endfunction
    assign take = INSTR_VALID_I && INSTR_READY_O;
    assign mv = take && (INSTR_I & MBS_MOVE_FP_MSK) == MBS_MOVE_FP_VAL;
    assign lo = take && (INSTR_I & MBS_BANK_LO_MSK) == MBS_BANK_LO_VAL;
    assign hi = take && (INSTR_I & MBS_BANK_HI_MSK) == MBS_BANK_HI_VAL;
    assign lw = take && (INSTR_I & MBS_LIT_W_MSK) == MBS_LIT_W_VAL;
    assign lc = take && (INSTR_I & MBS_LONG_CALL_MSK) == MBS_LONG_CALL_VAL;
    assign pf = plain(INSTR_I[7:0]);
    assign pp = plain({3'h0, INSTR_I[12:8]});

    a_move_read_addr: assert property (mv && pf |=> DMEM_RD_O && DMEM_ADDR_O == $past(INSTR_I[7:0]))
        else $error("source read address wrong");
    a_move_dest_addr: assert property (mv && pp |-> ##3 DMEM_WE_O && DMEM_ADDR_O == {3'h0, $past(INSTR_I[12:8], 3)})
        else $error("destination write address wrong");
    a_move_copy_data: assert property (mv && pf && pp |-> ##3 DMEM_WDATA_O == $past(DMEM_RDATA_I, 2))
        else $error("moved data differs from source");
    a_indirect_src: assert property (mv && INSTR_I[7:0] == MBS_INDIRECT0_ADDR && PTR0_I != MBS_WORKING_ADDR
        |=> DMEM_RD_O && DMEM_ADDR_O == $past(PTR0_I))
        else $error("indirect source not resolved");
    a_stray_write: assert property (DMEM_WE_O |-> $past(mv, 3))
        else $error("write without a move");
    a_single_cycle: assert property (take && !lc |=> !INSTR_READY_O [*3] ##1 INSTR_READY_O)
        else $error("instruction cycle length wrong");
    a_call_load: assert property (lc |-> ##3 STACK_PUSH_O && PC_LOAD_O
        && TOP_OF_STACK_O == $past(PC_I) + 16'h0001 && PC_LOW_BYTE_O == $past(INSTR_I[7:0], 3)
        && PC_HIGH_BYTE_O == $past(PC_HIGH_HOLDING_LATCH_I))
        else $error("long call push or load wrong");
    a_bank_low: assert property (lo |-> ##5 BANK_SELECT_REGISTER_O[3:0] == $past(INSTR_I[3:0], 5)
        && BANK_SELECT_REGISTER_O[7:4] == $past(BANK_SELECT_REGISTER_O[7:4], 4))
        else $error("low bank nibble load wrong");
    a_bank_high: assert property (hi |-> ##5 BANK_SELECT_REGISTER_O[7:4] == $past(INSTR_I[7:4], 5)
        && BANK_SELECT_REGISTER_O[3:0] == $past(BANK_SELECT_REGISTER_O[3:0], 4))
        else $error("high bank nibble load wrong");
    a_lit_working: assert property (lw |-> ##5 WORKING_REGISTER_O == $past(INSTR_I[7:0], 5))
        else $error("literal load wrong");
    c_move: cover property (mv && !pf);
    c_call: cover property (lc);
    c_back_to_back: cover property (take ##4 take);
endmodule

// File: tb_move_and_bank_select_decode.sv
`timescale 1ns/1ps
// bench signals keep the port names so the instance connects by name
module tb_move_and_bank_select_decode;
    import mbs_pkg::*;
    logic REF_CLK_I, RST_B_I, INSTR_VALID_I, INSTR_READY_O, DMEM_RD_O, DMEM_WE_O, STACK_PUSH_O, PC_LOAD_O;
    logic [15:0] INSTR_I, PC_I, TOP_OF_STACK_O, seed, r, w, exp_tos, exp_pc;
    // start values here, so the capture process stays their only writer
    logic [15:0] cap_tos = 16'h0000;
    logic [15:0] cap_pc = 16'h0000;
    logic [7:0] PC_HIGH_HOLDING_LATCH_I, PTR0_I, PTR1_I, DMEM_ADDR_O, DMEM_RDATA_I, DMEM_WDATA_O, PC_LOW_BYTE_O;
    logic [7:0] PC_HIGH_BYTE_O, WORKING_REGISTER_O, BANK_SELECT_REGISTER_O, exp_w, exp_bsr, v, d;
    logic [7:0] mem [256];
    logic [7:0] exp_mem [256];
    int fails, n_compared;

    mbs_move_bank_decode DUT (.REF_CLK_I, .RST_B_I, .INSTR_I, .INSTR_VALID_I, .INSTR_READY_O, .PC_I,
        .PC_HIGH_HOLDING_LATCH_I, .PTR0_I, .PTR1_I, .DMEM_ADDR_O, .DMEM_RD_O, .DMEM_RDATA_I, .DMEM_WE_O,
        .DMEM_WDATA_O, .STACK_PUSH_O, .TOP_OF_STACK_O, .PC_LOAD_O, .PC_LOW_BYTE_O, .PC_HIGH_BYTE_O,
        .WORKING_REGISTER_O, .BANK_SELECT_REGISTER_O);

    initial begin
        REF_CLK_I = 1'b0;
        forever #50 REF_CLK_I = ~REF_CLK_I;
    end

    // bench data memory answers reads at once and takes write pulses
    assign DMEM_RDATA_I = mem[DMEM_ADDR_O];
    always @(posedge REF_CLK_I) begin
        if (DMEM_WE_O === 1'b1)
            mem[DMEM_ADDR_O] <= DMEM_WDATA_O;
        if (STACK_PUSH_O === 1'b1 && PC_LOAD_O === 1'b1) begin
            cap_tos <= TOP_OF_STACK_O;
            cap_pc <= {PC_HIGH_BYTE_O, PC_LOW_BYTE_O};
        end
    end

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // one level of indirection, as the core resolves it
    function automatic logic [7:0] res(input logic [7:0] a);
        return a == MBS_INDIRECT0_ADDR ? PTR0_I : a == MBS_INDIRECT1_ADDR ? PTR1_I : a;
    endfunction
    // steers operands onto the special slots three times in four
    function automatic logic [7:0] pick(input logic [7:0] a, input logic [1:0] s);
        return s == 2'h0 ? 8'h00 : s == 2'h1 ? 8'h08 : s == 2'h2 ? 8'h0a : a;
    endfunction

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out;
        if (fails == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // offer a word and hold it until the core takes it
    task automatic issue(input logic [15:0] x);
        int n;
        n = 0;
        INSTR_I <= x;
        INSTR_VALID_I <= 1'b1;
        @(posedge REF_CLK_I);
        while (INSTR_READY_O !== 1'b1) begin
            n++;
            if (n > 20) begin
                fails++;
                close_out();
            end
            @(posedge REF_CLK_I);
        end
    endtask
    // let the last op land, then compare all visible state except memory location 10
    task automatic settle;
        INSTR_VALID_I <= 1'b0;
        repeat (6) @(posedge REF_CLK_I);
        check(WORKING_REGISTER_O, exp_w);
        check(BANK_SELECT_REGISTER_O, exp_bsr);
        check(cap_tos, exp_tos);
        check(cap_pc, exp_pc);
        for (int i = 0; i < 256; i++)
            if (i != 10) check(mem[i], exp_mem[i]);
    endtask

    initial begin
        {RST_B_I, INSTR_VALID_I, INSTR_I, PC_I, PC_HIGH_HOLDING_LATCH_I} = '0;
        {exp_tos, exp_pc, exp_w, exp_bsr} = '0;
        PTR0_I = 8'h10;
        PTR1_I = 8'h20;
        seed = 16'h0021;
        fails = 0;
        n_compared = 0;
        for (int i = 0; i < 256; i++) begin
            seed = lfsr(seed);
            mem[i] = seed[7:0];
            exp_mem[i] = seed[7:0];
        end
        repeat (12) @(posedge REF_CLK_I);
        RST_B_I <= 1'b1;
        for (int i = 0; i < 300; i++) begin
            seed = lfsr(seed);
            r = lfsr(seed);
            // context changes only while idle, so no op in flight sees it move
            if (seed[15] || i == 0) begin
                settle();
                PTR0_I <= r[7:0] | 8'h10;
                PTR1_I <= r[15:8] | 8'h10;
                PC_I <= r ^ seed;
                PC_HIGH_HOLDING_LATCH_I <= seed[7:0];
                @(posedge REF_CLK_I);
                @(posedge REF_CLK_I);
            end
            case (seed[2:0])
                3'h2: w = {8'hb8, r[7:0]};
                3'h3: w = {7'h5d, r[8:0]};
                3'h4: w = {8'hb0, r[7:0]};
                3'h5: w = {8'hb7, r[7:0]};
                3'h6: w = {4'h1, r[11:0]};
                default: begin
                    // peripheral field is five bits; the opcode must stay 011
                    d = pick({3'h0, r[12:8]}, r[14:13]);
                    w = {3'h3, d[4:0], pick(r[7:0], seed[9:8])};
                end
            endcase
            // expected effect of the word
            if (seed[2:0] == 3'h2) exp_bsr[3:0] = w[3:0];
            if (seed[2:0] == 3'h3) exp_bsr[7:4] = w[7:4];
            if (seed[2:0] == 3'h4) exp_w = w[7:0];
            if (seed[2:0] == 3'h5) begin
                exp_tos = PC_I + 16'h0001;
                exp_pc = {PC_HIGH_HOLDING_LATCH_I, w[7:0]};
            end
            if (seed[2:0] == 3'h0 || seed[2:0] == 3'h1 || seed[2:0] == 3'h7) begin
                v = res(w[7:0]) == MBS_WORKING_ADDR ? exp_w : exp_mem[res(w[7:0])];
                d = res({3'h0, w[12:8]});
                if (d == MBS_WORKING_ADDR) exp_w = v;
                else exp_mem[d] = v;
            end
            issue(w);
        end
        settle();
        close_out();
    end
endmodule

bind mbs_move_bank_decode mbs_move_bank_decode_sva u_sva (.REF_CLK_I, .RST_B_I, .INSTR_I, .INSTR_VALID_I,
    .INSTR_READY_O, .PC_I, .PC_HIGH_HOLDING_LATCH_I, .PTR0_I, .DMEM_ADDR_O, .DMEM_RD_O, .DMEM_RDATA_I,
    .DMEM_WE_O, .DMEM_WDATA_O, .STACK_PUSH_O, .TOP_OF_STACK_O, .PC_LOAD_O, .PC_LOW_BYTE_O, .PC_HIGH_BYTE_O,
    .WORKING_REGISTER_O, .BANK_SELECT_REGISTER_O);
